// ==== common/cyclic_timer_pkg.sv ====
/*
 * Constants for the cyclic sense timers and the switch supply fault policy:
 * register addresses, field positions, reset values, time bases and codes.
 * Assumes a 25 MHz core clock and 7-bit register addresses from the SPI frame decoder.
 */
package cyclic_timer_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_FIRST_TIMER  = 7'h0C;
    localparam logic [6:0] ADDR_SECOND_TIMER = 7'h0D;
    localparam logic [6:0] ADDR_FAULT_POLICY = 7'h10;
    localparam logic [7:0] REG_RESET         = 8'h00;
    localparam logic [7:0] TIMER_RW_MASK     = 8'h77;
    localparam logic [7:0] POLICY_RW_MASK    = 8'h70;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ON_MSB  = 6;
    localparam int ON_LSB  = 4;
    localparam int PER_MSB = 2;
    localparam int PER_LSB = 0;
    localparam int OV_DIS_BIT  = 6;
    localparam int UV_DIS_BIT  = 5;
    localparam int RECOVER_BIT = 4;

    // ------------------------------------------------------------------
    // On-time and period codes
    // ------------------------------------------------------------------
    localparam logic [2:0] ON_STOP_LOW  = 3'h0;
    localparam logic [2:0] ON_STOP_HIGH = 3'h6;
    localparam logic [2:0] ON_RESERVED  = 3'h7;
    localparam logic [2:0] PER_RESERVED = 3'h7;

    // ------------------------------------------------------------------
    // Switch configuration codes
    // ------------------------------------------------------------------
    localparam logic [2:0] HS_ON          = 3'h1;
    localparam logic [2:0] HS_FIRST_TIMER = 3'h2;
    localparam logic [2:0] HS_SECOND_TIMER = 3'h3;

    // ------------------------------------------------------------------
    // Time base: all on-times and periods are whole multiples of 0.1 ms.
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS       = 100000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 12;
    localparam int SPAN_W        = 15;

    // On-times in 0.1 ms ticks: 0.1, 0.3, 1.0, 10, 20 ms.
    localparam logic [SPAN_W-1:0] ON_T1 = 15'h0001;
    localparam logic [SPAN_W-1:0] ON_T2 = 15'h0003;
    localparam logic [SPAN_W-1:0] ON_T3 = 15'h000A;
    localparam logic [SPAN_W-1:0] ON_T4 = 15'h0064;
    localparam logic [SPAN_W-1:0] ON_T5 = 15'h00C8;
    // Periods in 0.1 ms ticks: 10, 20, 50, 100, 200 ms, 1 s, 2 s.
    localparam logic [SPAN_W-1:0] PER_T0 = 15'h0064;
    localparam logic [SPAN_W-1:0] PER_T1 = 15'h00C8;
    localparam logic [SPAN_W-1:0] PER_T2 = 15'h01F4;
    localparam logic [SPAN_W-1:0] PER_T3 = 15'h03E8;
    localparam logic [SPAN_W-1:0] PER_T4 = 15'h07D0;
    localparam logic [SPAN_W-1:0] PER_T5 = 15'h2710;
    localparam logic [SPAN_W-1:0] PER_T6 = 15'h4E20;
endpackage

// ==== src/cyclic_sense_timers.sv ====
/*
 * Two cyclic sense timers and the supply fault shutdown policy of four high-side outputs.
 * Assumes an SPI frame decoder that presents one-cycle write and read strobes with a 7-bit
 * address, and switch control logic that supplies the four 3-bit switch configurations.
 */
`timescale 1ns/1ns
`default_nettype none
module cyclic_sense_timers #(
    parameter int TICK_LEN = cyclic_timer_pkg::TICK_CYCLES
) (
    input  wire logic        clk,                 // 25 MHz core clock
    input  wire logic        rst_n,               // Asynchronous power-on reset, active low
    input  wire logic        soft_reset,          // Synchronous soft reset pulse
    input  wire logic        reg_wr,              // Register write strobe
    input  wire logic        reg_rd,              // Register read strobe
    input  wire logic [6:0]  reg_addr,            // Register address
    input  wire logic [7:0]  reg_wdata,           // Register write data
    output logic      [7:0]  reg_rdata,           // Read data, valid the cycle after reg_rd
    input  wire logic [11:0] hs_config,           // Four 3-bit switch configurations
    input  wire logic        restart_hs_clear,    // Switch settings cleared in restart mode
    input  wire logic [1:0]  timer_wake_en,       // Timer enabled as wake source
    input  wire logic        switch_supply_ov,    // Switch supply overvoltage
    input  wire logic        switch_supply_uv,    // Switch supply undervoltage
    output logic      [1:0]  timer_level,         // Current timer output levels
    output logic      [1:0]  cyclic_wake_sample,  // Pulse at end of on-time for wake filtering
    output logic      [3:0]  high_side_output,    // Switch drive
    output logic             supply_shutdown      // Switches held off by a supply fault
);
    import cyclic_timer_pkg::*;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [SPAN_W-1:0] on_ticks(input logic [2:0] code);
        case (code)
            3'h1:    on_ticks = ON_T1;
            3'h2:    on_ticks = ON_T2;
            3'h3:    on_ticks = ON_T3;
            3'h4:    on_ticks = ON_T4;
            3'h5:    on_ticks = ON_T5;
            default: on_ticks = '0;
        endcase
    endfunction

    function automatic logic [SPAN_W-1:0] per_ticks(input logic [2:0] code);
        case (code)
            3'h0:    per_ticks = PER_T0;
            3'h1:    per_ticks = PER_T1;
            3'h2:    per_ticks = PER_T2;
            3'h3:    per_ticks = PER_T3;
            3'h4:    per_ticks = PER_T4;
            3'h5:    per_ticks = PER_T5;
            3'h6:    per_ticks = PER_T6;
            default: per_ticks = '0;
        endcase
    endfunction

    // A timer is assigned when any switch names it.
    function automatic logic timer_assigned(input logic [11:0] cfg, input logic [2:0] sel);
        logic hit;
        hit = 1'b0;
        for (int s = 0; s < 4; s++) begin
            hit = hit | (cfg[3*s +: 3] == sel);
        end
        timer_assigned = hit;
    endfunction

    // ------------------------------------------------------------------
    // Shared 0.1 ms tick prescaler
    // ------------------------------------------------------------------
    logic [TICK_W-1:0] pre_cnt;
    wire               tick = (pre_cnt == TICK_W'(TICK_LEN - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= tick ? '0 : pre_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] fault_policy;
    logic [7:0] timer_reg [2];
    logic [1:0] timer_out;

    wire wr_policy = reg_wr && (reg_addr == ADDR_FAULT_POLICY);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_policy <= REG_RESET;
        end else if (soft_reset) begin
            fault_policy <= REG_RESET;
        end else if (wr_policy) begin
            fault_policy <= reg_wdata & POLICY_RW_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_timer
            logic [SPAN_W-1:0] span_cnt;
            wire  [2:0] on_code  = timer_reg[t][ON_MSB:ON_LSB];
            wire  [2:0] per_code = timer_reg[t][PER_MSB:PER_LSB];
            wire  [6:0] my_addr  = (t == 0) ? ADDR_FIRST_TIMER : ADDR_SECOND_TIMER;
            wire  [2:0] my_sel   = (t == 0) ? HS_FIRST_TIMER : HS_SECOND_TIMER;
            wire        wr_hit   = reg_wr && (reg_addr == my_addr);
            // Clearing the timer avoids a false open-load reading after restart.
            wire        sense_clear = restart_hs_clear && timer_assigned(hs_config, my_sel);
            // Codes 0, 6 and 7 and a reserved period leave the timer stopped.
            wire        running  = (on_code != ON_STOP_LOW) && (on_code != ON_STOP_HIGH) &&
                                   (on_code != ON_RESERVED) && (per_code != PER_RESERVED);
            wire        last     = (span_cnt == per_ticks(per_code) - 1'b1);
            wire        on_phase = running && (span_cnt < on_ticks(on_code));
            wire        on_end   = running && tick && (span_cnt == on_ticks(on_code) - 1'b1);
            wire        next_out = on_phase || (on_code == ON_STOP_HIGH);

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    timer_reg[t] <= REG_RESET;
                end else if (soft_reset || sense_clear) begin
                    timer_reg[t] <= REG_RESET;
                end else if (wr_hit) begin
                    timer_reg[t] <= reg_wdata & TIMER_RW_MASK;
                end
            end

            // Any write restarts the period, so a running code starts a fresh cycle at once.
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    span_cnt <= '0;
                end else if (wr_hit || !running) begin
                    span_cnt <= '0;
                end else if (tick) begin
                    span_cnt <= last ? '0 : span_cnt + 1'b1;
                end
            end

            // Wake sampling is independent of switch use, so both run from one count.
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    timer_out[t]          <= 1'b0;
                    cyclic_wake_sample[t] <= 1'b0;
                end else begin
                    timer_out[t]          <= next_out;
                    cyclic_wake_sample[t] <= on_end && timer_wake_en[t];
                end
            end
        end
    endgenerate

    assign timer_level = timer_out;

    // ------------------------------------------------------------------
    // Supply fault policy
    // ------------------------------------------------------------------
    logic shut_latched;

    wire ov_trip   = switch_supply_ov && !fault_policy[OV_DIS_BIT];
    wire uv_trip   = switch_supply_uv && !fault_policy[UV_DIS_BIT];
    wire fault_now = ov_trip || uv_trip;
    // Without recovery the outputs stay off until software turns every switch off.
    wire all_off   = (hs_config == 12'h000);
    wire release_ok = !fault_now && (fault_policy[RECOVER_BIT] || all_off);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shut_latched <= 1'b0;
        end else if (fault_now) begin
            shut_latched <= 1'b1;
        end else if (release_ok) begin
            shut_latched <= 1'b0;
        end
    end

    logic [3:0] next_hs;
    always_comb begin
        next_hs = '0;
        for (int s = 0; s < 4; s++) begin
            case (hs_config[3*s +: 3])
                HS_ON:           next_hs[s] = 1'b1;
                HS_FIRST_TIMER:  next_hs[s] = timer_out[0];
                HS_SECOND_TIMER: next_hs[s] = timer_out[1];
                default:         next_hs[s] = 1'b0;
            endcase
        end
    end

    wire shut_next = fault_now || (shut_latched && !release_ok);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_side_output <= '0;
            supply_shutdown  <= 1'b0;
        end else begin
            high_side_output <= shut_next ? 4'h0 : next_hs;
            supply_shutdown  <= shut_next;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire [7:0] rd_mux = (reg_addr == ADDR_FIRST_TIMER)  ? timer_reg[0] :
                        (reg_addr == ADDR_SECOND_TIMER) ? timer_reg[1] :
                        (reg_addr == ADDR_FAULT_POLICY) ? fault_policy : 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end
endmodule // cyclic_sense_timers
`default_nettype wire

// ==== testbench/cyclic_sense_timers_assertions.sv ====
/* Port checker for the cyclic sense timers.
   Assumes one clock domain and a bind onto cyclic_sense_timers. */
`timescale 1ns/1ns
`default_nettype none
module cyclic_sense_timers_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        soft_reset,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [6:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic [1:0]  timer_wake_en,
    input wire logic [11:0] hs_config,      // Four 3-bit switch configurations
    input wire logic        switch_supply_ov,
    input wire logic        switch_supply_uv,
    input wire logic [1:0]  timer_level,
    input wire logic [1:0]  cyclic_wake_sample,
    input wire logic [3:0]  high_side_output,
    input wire logic        supply_shutdown
);
    import cyclic_timer_pkg::*;
    logic [7:0] policy;  // Shadow copy, since the checker cannot see the register itself.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            policy <= 8'h00;
        end else if (soft_reset) begin
            policy <= 8'h00;
        end else if (reg_wr && reg_addr == ADDR_FAULT_POLICY) begin
            policy <= reg_wdata & POLICY_RW_MASK;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_OV_OFF: assert property (switch_supply_ov && !policy[6] && !reg_wr |=> high_side_output == 4'h0)
        else $error("switch on during overvoltage");
    AST_UV_OFF: assert property (switch_supply_uv && !policy[5] && !reg_wr |=> high_side_output == 4'h0)
        else $error("switch on during undervoltage");
    AST_RSV_ZERO: assert property (reg_rd |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
        else $error("reserved bit read as one");
    AST_POL_LOW: assert property (reg_rd && reg_addr == ADDR_FAULT_POLICY |=> reg_rdata[3:0] == 4'h0)
        else $error("policy low bits not zero");
    AST_RST_IDLE: assert property ($rose(rst_n) |-> timer_level == 2'b00 && high_side_output == 4'h0)
        else $error("outputs active after reset");
    AST_FOLLOW: assert property (hs_config[2:0] == HS_FIRST_TIMER |=> supply_shutdown || high_side_output[0] == $past(timer_level[0]))
        else $error("switch does not follow its timer");
    AST_SHUT_OFF: assert property (supply_shutdown |-> high_side_output == 4'h0)
        else $error("switch on while shut down");
    AST_WAKE_GATE: assert property (!$past(timer_wake_en[0]) |-> !cyclic_wake_sample[0])
        else $error("wake sample without wake enable");
    AST_UNMAPPED: assert property (reg_rd && reg_addr == 7'h0E |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    C_OV: cover property (switch_supply_ov ##1 supply_shutdown);
    C_WAKE: cover property (cyclic_wake_sample[0]);
    C_RUN: cover property ($rose(timer_level[0]));
endmodule // cyclic_sense_timers_checker
bind cyclic_sense_timers cyclic_sense_timers_checker checker_inst (.clk(clk), .rst_n(rst_n),
    .soft_reset(soft_reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .timer_wake_en(timer_wake_en), .hs_config(hs_config), .switch_supply_ov(switch_supply_ov),
    .switch_supply_uv(switch_supply_uv), .timer_level(timer_level), .cyclic_wake_sample(cyclic_wake_sample),
    .high_side_output(high_side_output), .supply_shutdown(supply_shutdown));
`default_nettype wire

// ==== testbench/reg_host_model.sv ====
/* Host side of the register strobes, as left by the SPI frame decoder.
   Assumes requests change at the falling edge and read data settles one edge later. */
`timescale 1ns/1ns
`default_nettype none
module reg_host_model (
    input  wire logic       clk,        // Core clock
    output logic            reg_wr,     // Write strobe
    output logic            reg_rd,     // Read strobe
    output logic      [6:0] reg_addr,   // Register address
    output logic      [7:0] reg_wdata,  // Write data
    input  wire logic [7:0] reg_rdata   // Read data
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    // Callers may also write a running on-time to a timer that no switch names.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;  // An idle bus must not look like the last value.
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule // reg_host_model
`default_nettype wire

// ==== testbench/cyclic_sense_timers_tb.sv ====
/* Self-checking bench for the cyclic sense timers.
   Assumes a shortened 0.1 ms tick of four clocks. */
`timescale 1ns/1ns
`default_nettype none
module cyclic_sense_timers_tb;
    import cyclic_timer_pkg::*;
    localparam int TK = 4;
    logic clk, rst_n, soft_reset, restart_hs_clear, ov, uv, reg_wr, reg_rd;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [11:0] hs_config;
    logic [1:0] wake_en, timer_level, cyclic_wake_sample;
    logic [3:0] high_side_output;
    logic supply_shutdown;
    int n_errors = 0;
    int samples_checked = 0;
    logic [6:0] adr [3] = '{ADDR_FIRST_TIMER, ADDR_SECOND_TIMER, ADDR_FAULT_POLICY};
    logic [7:0] msk [3] = '{8'h77, 8'h77, 8'h70};
    int on_t [5] = '{1, 3, 10, 100, 200};
    int per_t [5] = '{100, 200, 500, 1000, 2000};
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value t=%0t got %0h expected %0h", $time, g, e); end end
    cyclic_sense_timers #(.TICK_LEN(TK)) cyclic_sense_timers_inst (.clk(clk), .rst_n(rst_n),
        .soft_reset(soft_reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .hs_config(hs_config), .restart_hs_clear(restart_hs_clear),
        .timer_wake_en(wake_en), .switch_supply_ov(ov), .switch_supply_uv(uv), .timer_level(timer_level),
        .cyclic_wake_sample(cyclic_wake_sample), .high_side_output(high_side_output),
        .supply_shutdown(supply_shutdown));
    reg_host_model reg_host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic fault(input logic o, input logic u, input logic e);
        ov = o;
        uv = u;
        repeat (3) @(negedge clk);
        `CHK(high_side_output[0], e)
        `CHK(supply_shutdown, ~e)
    endtask
    // The first period after a write may be short, so counting starts at the second rise.
    task automatic measure(input int i);
        int n, hi, hs, wk;
        hi = 0;
        hs = 0;
        wk = 0;
        reg_host_model_inst.wr(ADDR_FIRST_TIMER, {1'b0, 3'(i + 1), 1'b0, 3'(i)});
        for (n = 0; n < 3 * per_t[i] * TK && timer_level[0] !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 3 * per_t[i] * TK && timer_level[0] !== 1'b0; n++) @(negedge clk);
        for (n = 0; n < 3 * per_t[i] * TK && timer_level[0] !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < per_t[i] * TK; n++) begin
            hi += int'(timer_level[0] === 1'b1);
            hs += int'(high_side_output[0] === 1'b1);
            wk += int'(cyclic_wake_sample[0] === 1'b1);
            @(negedge clk);
        end
        `CHK(hi, on_t[i] * TK)
        `CHK(timer_level[0], 1'b1)
        `CHK(hs, on_t[i] * TK)
        `CHK(wk, 1)
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #2400000;
        n_errors++;
        final_report;
    end
    initial begin
        {rst_n, soft_reset, restart_hs_clear, ov, uv, hs_config, wake_en} = '0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            reg_host_model_inst.rd(adr[i], d);
            `CHK(d, 8'h00)
            reg_host_model_inst.wr(adr[i], 8'hFF);
            reg_host_model_inst.rd(adr[i], d);
            `CHK(d, msk[i])
        end
        reg_host_model_inst.rd(7'h0E, d);
        `CHK(d, 8'h00)
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        for (int i = 0; i < 3; i++) begin
            reg_host_model_inst.rd(adr[i], d);
            `CHK(d, 8'h00)
        end
        hs_config = 12'h002;
        reg_host_model_inst.wr(ADDR_FIRST_TIMER, 8'h60);
        repeat (3) @(negedge clk);
        `CHK(high_side_output[0], 1'b1)
        reg_host_model_inst.wr(ADDR_FIRST_TIMER, 8'h17);
        repeat (3 * TK) @(negedge clk);
        `CHK(timer_level[0], 1'b0)
        reg_host_model_inst.wr(ADDR_FIRST_TIMER, 8'h60);
        reg_host_model_inst.wr(ADDR_FIRST_TIMER, 8'h70);
        repeat (3 * TK) @(negedge clk);
        `CHK(timer_level[0], 1'b0)
        reg_host_model_inst.wr(ADDR_FIRST_TIMER, 8'h60);
        reg_host_model_inst.wr(ADDR_FIRST_TIMER, 8'h00);
        repeat (3 * TK) @(negedge clk);
        `CHK(high_side_output[0], 1'b0)
        wake_en = 2'b01;
        for (int i = 0; i < 5; i++)
            measure(i);
        reg_host_model_inst.wr(ADDR_FIRST_TIMER, 8'h13);
        reg_host_model_inst.wr(ADDR_SECOND_TIMER, 8'h13);
        restart_hs_clear = 1'b1;
        @(negedge clk);
        restart_hs_clear = 1'b0;
        reg_host_model_inst.rd(ADDR_FIRST_TIMER, d);
        `CHK(d, 8'h00)
        reg_host_model_inst.rd(ADDR_SECOND_TIMER, d);
        `CHK(d, 8'h13)
        hs_config = 12'h458;
        reg_host_model_inst.wr(ADDR_SECOND_TIMER, 8'h60);
        repeat (3) @(negedge clk);
        `CHK(timer_level, 2'b10)
        `CHK(high_side_output, 4'h6)
        hs_config = 12'h001;
        fault(1'b1, 1'b0, 1'b0);
        fault(1'b0, 1'b0, 1'b0);
        reg_host_model_inst.wr(ADDR_FAULT_POLICY, 8'h10);
        hs_config = 12'h000;
        repeat (2) @(negedge clk);
        hs_config = 12'h001;
        fault(1'b0, 1'b1, 1'b0);
        fault(1'b0, 1'b0, 1'b1);
        reg_host_model_inst.wr(ADDR_FAULT_POLICY, 8'h40);
        fault(1'b1, 1'b0, 1'b1);
        reg_host_model_inst.wr(ADDR_FAULT_POLICY, 8'h20);
        fault(1'b0, 1'b1, 1'b1);
        final_report;
    end
endmodule // cyclic_sense_timers_tb
`default_nettype wire
